// *** rtl/bc_flags_pkg.sv ***
/*
  Constants for the bus controller general purpose flag block:
  register index and byte address, field positions, reset values.
  Assumes a 32-bit APB with byte addresses and 12 address bits.
*/
package bc_flags_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // printed offset is an index; byte address is four times it
  localparam int unsigned GPF_INDEX    = 'h37;
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] GPF_ADDR     = 12'(GPF_INDEX * 4);

  // ****************************************************************
  // flag register fields
  // ****************************************************************
  localparam logic [7:0]  FLAG_MASK    = 8'h3e;  // flags one..five
  localparam logic [7:0]  FLAG_RESET   = 8'h00;
  localparam int unsigned EQUAL_BIT    = 1;      // shared equal flag
  localparam int unsigned SET_LSB      = 0;      // write: set byte
  localparam int unsigned CLR_LSB      = 8;      // write: clear byte

  // ****************************************************************
  // condition field
  // ****************************************************************
  localparam int unsigned INV_BIT      = 4;
  localparam logic [3:0]  CODE_EQUAL   = 4'h1;
  localparam logic [3:0]  CODE_GP_LO   = 4'h2;
  localparam logic [3:0]  CODE_GP_HI   = 4'h5;

endpackage

// *** rtl/cond_eval.sv ***
/*
  Combinational evaluation of a five-bit condition field against
  the current flag byte. Assumes the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none

module cond_eval (
  // flag state
  input  wire logic [7:0] flags,
  // condition field from the sequencer
  input  wire logic [4:0] code,
  // result
  output logic            in_scope,
  output logic            execute
);

  // ****************************************************************
  // evaluation
  // ****************************************************************
  // codes outside one..five belong to other logic; report them
  always_comb begin
    in_scope = (code[3:0] >= bc_flags_pkg::CODE_EQUAL) &&
               (code[3:0] <= bc_flags_pkg::CODE_GP_HI);
    // inverse bit flips the tested sense only
    execute  = in_scope &&
               (flags[code[2:0]] ^ code[bc_flags_pkg::INV_BIT]);
  end

endmodule

`default_nettype wire

// *** rtl/bc_condition_flags_gp.sv ***
/*
  General purpose flags one to five of a bus controller: sequencer
  flag and timer-compare updates, host access over APB, and
  evaluation of the condition field. Assumes one clock, the
  sequencer issues at most one op code per cycle, and a plain
  APB master.
*/
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - code one tests equal flag, inverse tests unequal
// - flag op or host write toggles/sets/clears flags
// - timer compare ops update flag one
// - parameter equal to timer sets flag one
// - parameter unequal to timer clears flag one
// - codes two..five test flags two..five
// - bit four selects required true or false outcome
// - host reads condition bits, writes update flags
module bc_condition_flags_gp (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // flag manipulation op code from the sequencer
  input  wire logic        flag_manipulate_op,
  input  wire logic [7:0]  op_set,
  input  wire logic [7:0]  op_clear,
  // timer compare op codes
  input  wire logic        message_timer_compare_op,
  input  wire logic        frame_timer_compare_op,
  input  wire logic [15:0] compare_param,
  input  wire logic [15:0] time_to_next_msg,
  input  wire logic [15:0] frame_time_left,
  // condition evaluation
  input  wire logic        cond_valid,
  input  wire logic [4:0]  cond_code,
  output logic             cond_done,
  output logic             cond_in_scope,
  output logic             cond_execute,
  // flag state for the sequencer
  output logic [7:0]       flags
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  flags_ff;        // flag byte, bits one..five live
  logic [7:0]  nxt_flags;
  logic        pready_ff;       // one wait state per transfer
  logic        nxt_pready;
  logic [31:0] prdata_ff;       // read data, loaded with pready
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;      // unmapped address answer
  logic        nxt_pslverr;
  logic        done_ff;         // evaluation result valid
  logic        nxt_done;
  logic        scope_ff;
  logic        nxt_scope;
  logic        exec_ff;
  logic        nxt_exec;
  logic        eval_scope;      // combinational evaluator outputs
  logic        eval_exec;
  logic        addr_hit;        // paddr decodes to the flag word
  logic        host_wr;         // write takes effect this edge
  logic        cmp_equal;       // compare outcome

  // ****************************************************************
  // helpers
  // ****************************************************************
  // set and clear together toggle; used by sequencer and host
  function automatic logic [7:0] apply_update(input logic [7:0] f,
                                              input logic [7:0] s,
                                              input logic [7:0] c);
    logic [7:0] r;
    r = (f & ~(s | c)) | (s & ~c) | (s & c & ~f);
    return r;
  endfunction

  assign addr_hit = (paddr == bc_flags_pkg::GPF_ADDR);
  assign host_wr  = psel && penable && pready_ff && pwrite && addr_hit;

  // message compare wins if the sequencer ever raises both
  assign cmp_equal = message_timer_compare_op ?
                     (compare_param == time_to_next_msg) :
                     (compare_param == frame_time_left);

  // ****************************************************************
  // flag update
  // ****************************************************************
  // order: flag op, then compare, then host write on top
  always_comb begin
    nxt_flags = flags_ff;
    if (flag_manipulate_op) begin
      nxt_flags = apply_update(nxt_flags, op_set, op_clear);
    end
    if (message_timer_compare_op || frame_timer_compare_op) begin
      // equal sets, less or greater clears
      nxt_flags[bc_flags_pkg::EQUAL_BIT] = cmp_equal;
    end
    if (host_wr) begin
      // host is last so a same-cycle clash ends in its value
      nxt_flags = apply_update(nxt_flags,
                               pwdata[bc_flags_pkg::SET_LSB +: 8],
                               pwdata[bc_flags_pkg::CLR_LSB +: 8]);
    end
    // unimplemented flag bits never hold a one
    nxt_flags = nxt_flags & bc_flags_pkg::FLAG_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= bc_flags_pkg::FLAG_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // read data is sampled in the first access cycle, so a flag
  // change on the completing edge shows only on the next read
  always_comb begin
    nxt_pready  = psel && penable && !pready_ff;
    nxt_prdata  = 32'h0;
    nxt_pslverr = 1'b0;
    if (nxt_pready) begin
      if (addr_hit && !pwrite) begin
        nxt_prdata = {24'h0, flags_ff};
      end
      nxt_pslverr = !addr_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ****************************************************************
  // condition evaluation
  // ****************************************************************
  cond_eval u_eval (
    .flags    (flags_ff),
    .code     (cond_code),
    .in_scope (eval_scope),
    .execute  (eval_exec)
  );

  // result held until the next request
  always_comb begin
    nxt_done  = cond_valid;
    nxt_scope = scope_ff;
    nxt_exec  = exec_ff;
    if (cond_valid) begin
      nxt_scope = eval_scope;
      nxt_exec  = eval_exec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff  <= 1'b0;
      scope_ff <= 1'b0;
      exec_ff  <= 1'b0;
    end else begin
      done_ff  <= nxt_done;
      scope_ff <= nxt_scope;
      exec_ff  <= nxt_exec;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready        = pready_ff;
  assign prdata        = prdata_ff;
  assign pslverr       = pslverr_ff;
  assign cond_done     = done_ff;
  assign cond_in_scope = scope_ff;
  assign cond_execute  = exec_ff;
  assign flags         = flags_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rd_first;
    psel && penable && !pwrite && addr_hit && !pready_ff;
  endsequence

  sequence rd_done;
    rd_first ##1 pready_ff;
  endsequence

  a_equal_flag_test: assert property (
    cond_valid && cond_code == 5'h11 |=>
      cond_execute == !$past(flags_ff[1]))
    else $error("inverse code one not the unequal sense");

  a_host_set_flag: assert property (
    host_wr && pwdata[2] && !pwdata[10] |=> flags_ff[2])
    else $error("host set of flag two lost");

  a_op_clear_flag: assert property (
    flag_manipulate_op && op_clear[1] && !op_set[1] && !host_wr &&
    !message_timer_compare_op && !frame_timer_compare_op
      |=> !flags_ff[1])
    else $error("flag op clear of flag one lost");

  a_cmp_equal_set: assert property (
    frame_timer_compare_op && !message_timer_compare_op && !host_wr &&
    compare_param == frame_time_left |=> flags_ff[1])
    else $error("equal compare did not set flag one");

  a_cmp_unequal_clr: assert property (
    message_timer_compare_op && !host_wr &&
    compare_param != time_to_next_msg |=> !flags_ff[1])
    else $error("unequal compare did not clear flag one");

  a_gp_flags_stable: assert property (
    !flag_manipulate_op && !host_wr |=> $stable(flags_ff[5:2]))
    else $error("flags two..five changed without an update");

  a_bit4_sense: assert property (
    cond_valid && cond_code[3:0] >= 4'h2 && cond_code[3:0] <= 4'h5
      |=> cond_execute == ($past(flags_ff[cond_code[2:0]]) ^
                           $past(cond_code[4])))
    else $error("condition sense wrong for codes two..five");

  a_read_flags: assert property (
    rd_first |=> prdata_ff == {24'h0, $past(flags_ff)})
    else $error("read data differs from flag state");

  a_read_ok: assert property (
    rd_done |-> !pslverr_ff)
    else $error("mapped read answered with error");

  a_host_wins: assert property (
    host_wr && flag_manipulate_op && pwdata[9] && !pwdata[1]
      |=> !flags_ff[1])
    else $error("host write did not win over flag op");

endmodule

`default_nettype wire

// *** tb/seq_model.sv ***
/*
  sequencer model: drives flag, timer-compare and condition strobes.
  assumes the caller starts each task just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module seq_model #(
  parameter logic [15:0] MSG_T = 16'h0040,  // time to next message
  parameter logic [15:0] FRM_T = 16'h0100   // frame time remaining
) (
  // clock
  input  wire logic  pclk,
  // op strobes
  output logic       flag_manipulate_op,
  output logic [7:0] op_set,
  output logic [7:0] op_clear,
  output logic       message_timer_compare_op,
  output logic       frame_timer_compare_op,
  output logic [15:0] compare_param,
  // timers held still so expectations stay simple
  output logic [15:0] time_to_next_msg,
  output logic [15:0] frame_time_left,
  // condition request
  output logic       cond_valid,
  output logic [4:0] cond_code
);
  // ****************************************************************
  // idle levels and timers
  // ****************************************************************
  assign time_to_next_msg = MSG_T;
  assign frame_time_left  = FRM_T;

  initial begin
    flag_manipulate_op = 1'b0;
    op_set = 8'h00;
    op_clear = 8'h00;
    message_timer_compare_op = 1'b0;
    frame_timer_compare_op = 1'b0;
    compare_param = 16'h0000;
    cond_valid = 1'b0;
    cond_code = 5'h00;
  end

  // ****************************************************************
  // requests
  // ****************************************************************
  // strobe held n edges: each edge is a separate flag op
  task automatic flag_op(input logic [7:0] s, c, input int n);
    @(posedge pclk);
    flag_manipulate_op <= 1'b1;
    op_set <= s;
    op_clear <= c;
    repeat (n) @(posedge pclk);
    flag_manipulate_op <= 1'b0;
  endtask

  // one compare, message or frame timer
  task automatic cmp(input logic frame, input logic [15:0] p);
    @(posedge pclk);
    message_timer_compare_op <= !frame;
    frame_timer_compare_op <= frame;
    compare_param <= p;
    @(posedge pclk);
    message_timer_compare_op <= 1'b0;
    frame_timer_compare_op <= 1'b0;
  endtask

  // one condition evaluation
  task automatic cond(input logic [4:0] c);
    @(posedge pclk);
    cond_valid <= 1'b1;
    cond_code <= c;
    @(posedge pclk);
    cond_valid <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
  self-checking bench: apb host tasks plus the sequencer model.
  assumes the apb slave answers with bounded wait states.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam logic [15:0] MT  = 16'h0040;  // message timer
  localparam logic [15:0] FT  = 16'h0100;  // frame timer
  localparam logic [11:0] GPF = bc_flags_pkg::GPF_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        flag_manipulate_op, message_timer_compare_op;
  logic        frame_timer_compare_op, cond_valid, cond_done;
  logic        cond_in_scope, cond_execute;
  logic [7:0]  op_set, op_clear, flags, expf;
  logic [15:0] compare_param, time_to_next_msg, frame_time_left;
  logic [4:0]  cond_code;
  int          fails, checks;

  bc_condition_flags_gp u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .flag_manipulate_op(flag_manipulate_op),
    .op_set(op_set), .op_clear(op_clear),
    .message_timer_compare_op(message_timer_compare_op),
    .frame_timer_compare_op(frame_timer_compare_op),
    .compare_param(compare_param), .time_to_next_msg(time_to_next_msg),
    .frame_time_left(frame_time_left), .cond_valid(cond_valid),
    .cond_code(cond_code), .cond_done(cond_done),
    .cond_in_scope(cond_in_scope), .cond_execute(cond_execute),
    .flags(flags));

  seq_model #(.MSG_T(MT), .FRM_T(FT)) u_seq (.pclk(pclk),
    .flag_manipulate_op(flag_manipulate_op), .op_set(op_set),
    .op_clear(op_clear), .compare_param(compare_param),
    .message_timer_compare_op(message_timer_compare_op),
    .frame_timer_compare_op(frame_timer_compare_op),
    .time_to_next_msg(time_to_next_msg),
    .frame_time_left(frame_time_left), .cond_valid(cond_valid),
    .cond_code(cond_code));

  // ****************************************************************
  // helpers
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // one apb transfer; read data and error land in r and e
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // set, clear, both means toggle; only flags one..five live
  function automatic logic [7:0] upd(input logic [7:0] f, s, c);
    return ((f & ~(s | c)) | (s & ~c) | (~f & s & c))
           & bc_flags_pkg::FLAG_MASK;
  endfunction

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_host;
    logic [31:0] w [4] = '{32'h0000_00ff, 32'h0000_0c00,
                           32'h0000_1212, 32'hffff_0000};
    apb(1'b0, GPF, 32'h0);
    chk(r, 32'h0);
    foreach (w[i]) begin
      apb(1'b1, GPF, w[i]);
      expf = upd(expf, w[i][7:0], w[i][15:8]);
      apb(1'b0, GPF, 32'h0);
      chk(r, {24'h0, expf});
    end
    apb(1'b1, GPF + 12'h004, 32'h0000_0f00);
    chk(32'(e), 32'h1);
    apb(1'b0, GPF, 32'h0);
    chk(32'(e), 32'h0);
    chk(r, {24'h0, expf});
  endtask

  task automatic t_flag;
    logic [15:0] p [3] = '{16'h00ff, 16'h1600, 16'h2222};
    foreach (p[i]) begin
      u_seq.flag_op(p[i][7:0], p[i][15:8], 1);
      expf = upd(expf, p[i][7:0], p[i][15:8]);
      @(negedge pclk);
      chk(32'(flags), 32'(expf));
    end
  endtask

  // equal sets flag one, other timer or unequal clears it
  task automatic t_cmp;
    logic [15:0] p [6];
    logic [15:0] t, o;
    for (int f = 0; f < 2; f++) begin
      t = f ? FT : MT;
      o = f ? MT : FT;
      p = '{t, o, t, t - 16'h1, t, t + 16'h1};
      foreach (p[i]) begin
        u_seq.cmp(f[0], p[i]);
        expf[1] = (i % 2 == 0);
        @(negedge pclk);
        chk(32'(flags), 32'(expf));
      end
    end
  endtask

  task automatic t_cond;
    logic [7:0] pat [2] = '{8'h14, 8'h2a};
    logic x, s;
    foreach (pat[j]) begin
      apb(1'b1, GPF, {16'h0, ~pat[j], pat[j]});
      expf = pat[j];
      for (int c = 0; c < 32; c++) begin
        u_seq.cond(c[4:0]);
        @(negedge pclk);
        s = c[3:0] >= 4'h1 && c[3:0] <= 4'h5;
        x = s ? expf[c[2:0]] ^ c[4] : 1'b0;
        chk(32'({cond_done, cond_in_scope, cond_execute}),
            {29'h0, 1'b1, s, x});
      end
    end
  endtask

  // host clear and op set of flag one at one edge: host wins
  task automatic t_race;
    fork
      apb(1'b1, GPF, 32'h0000_0200);
      begin
        @(posedge pclk);
        u_seq.flag_op(8'h02, 8'h00, 2);
      end
    join
    expf[1] = 1'b0;
    @(negedge pclk);
    chk(32'(flags), 32'(expf));
  endtask

  // mid-run reset empties the flag byte; first read right after
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    expf = 8'h00;
    @(negedge pclk);
    chk(32'(flags), 32'(expf));
    apb(1'b0, GPF, 32'h0);
    chk(r, {24'h0, expf});
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    expf = 8'h00;
    fails = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_host;
    t_flag;
    t_cmp;
    t_cond;
    t_race;
    t_reset;
    close_out;
  end

  // about 220 cycles expected; allow a wide margin
  initial begin
    #500000;
    fails++;
    close_out;
  end
endmodule

`default_nettype wire
